// *** dpw_modulator.sv ***
// Purpose: dual pwm / sigma-delta dac with apb registers
// Assumes: pclk 50 MHz; source ticks and external pin synchronous to pclk
// Notes: counter clock is a one-cycle enable; outputs drive only when enabled
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dpw_modulator
    import dpw_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter clock sources, two enables and a pin level, all in pclk domain
    input wire logic xtal_tick,
    input wire logic vco_tick,
    input wire logic external_clock_pin,
    // output pins
    output logic output_a,
    output logic output_a_oe,
    output logic output_b,
    output logic output_b_oe
);
    // whole state of the block
    typedef struct packed {
        logic [7:0] ctl;      // modulator_control
        logic [7:0] hold_a;   // hidden low byte, channel a
        logic [7:0] hold_b;   // hidden low byte, channel b
        logic [15:0] pend_a;  // committed, waits for next cycle
        logic [15:0] pend_b;
        logic [15:0] act_a;   // values in use this cycle
        logic [15:0] act_b;
        logic [15:0] cnt;     // main counter
        logic [7:0] cnt_b;    // second counter, dual 8-bit only
        logic [15:0] acc_a;   // sigma-delta accumulators
        logic [15:0] acc_b;
        logic [5:0] pre;      // prescaler
        logic [3:0] x15;      // crystal divide by 15
        logic ext_prev;       // external pin, last sample
        logic [15:0] ph;      // pclk cycles since counter tick
        logic [15:0] per;     // length of last counter clock
        logic lvl_a;          // modulator levels before gating
        logic lvl_b;
        logic out_a;
        logic out_b;
        logic oe_a;
        logic oe_b;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } dpw_state_t;
    dpw_state_t st_reg;
    dpw_state_t st_next;
    // prescaler terminal count per code
    function automatic logic [5:0] dpw_pre_last(input logic [1:0] code);
        case (code)
            2'h0: dpw_pre_last = DPW_PRE_L1;
            2'h1: dpw_pre_last = DPW_PRE_L4;
            2'h2: dpw_pre_last = DPW_PRE_L16;
            default: dpw_pre_last = DPW_PRE_L64;
        endcase
    endfunction
    // true when the address names a mapped register
    function automatic logic dpw_mapped(input logic [7:0] a);
        dpw_mapped = (a == DPW_OFF_CTL) || (a == DPW_OFF_A_LO) || (a == DPW_OFF_A_HI) ||
                     (a == DPW_OFF_B_LO) || (a == DPW_OFF_B_HI) || (a == DPW_OFF_STAT);
    endfunction
    // sixteen-bit value modes use the hidden low byte
    function automatic logic dpw_wide(input logic [2:0] m);
        dpw_wide = (m == DPW_M_SINGLE) || (m == DPW_M_TWIN16) || (m == DPW_M_NRZ) || (m == DPW_M_RZ);
    endfunction
    // decoded views of the current state
    logic [2:0] mode;
    logic wr_go;
    logic ctl_wr;
    logic src_tick;
    logic ctick;
    logic [15:0] last;
    logic wrap;
    logic [16:0] sum_a;
    logic [16:0] sum_b;
    logic rz_on;
    logic [2:0] nmode;
    assign mode = st_reg.ctl[DPW_MODE_HI:DPW_MODE_LO];
    assign wr_go = psel && penable && st_reg.rdy && pwrite;
    assign ctl_wr = wr_go && (paddr == DPW_OFF_CTL);
    assign sum_a = {1'b0, st_reg.acc_a} + {1'b0, st_reg.act_a};
    assign sum_b = {1'b0, st_reg.acc_b} + {1'b0, st_reg.act_b};
    // source select and prescaler chain
    always_comb
    begin
        case (st_reg.ctl[DPW_SRC_HI:DPW_SRC_LO])
            DPW_SRC_X15: src_tick = xtal_tick && (st_reg.x15 == DPW_X15_LAST);
            DPW_SRC_XTAL: src_tick = xtal_tick;
            DPW_SRC_EXT: src_tick = external_clock_pin && !st_reg.ext_prev;
            default: src_tick = vco_tick;
        endcase
        // one prescaler feeds both channels in every mode
        ctick = src_tick && (st_reg.pre == dpw_pre_last(st_reg.ctl[DPW_DIV_HI:DPW_DIV_LO]));
    end
    // last count of the main counter in each mode
    always_comb
    begin
        case (mode)
            DPW_M_SINGLE: last = st_reg.act_b - DPW_ONE16;
            DPW_M_TWIN8: last = {DPW_ZERO8, st_reg.act_b[7:0]};
            DPW_M_DUAL8: last = {DPW_ZERO8, st_reg.act_b[7:0]};
            default: last = DPW_FULL;
        endcase
        wrap = (st_reg.cnt == last);
        // the tick edge itself shows the first pclk, so pclk ph+1 must stay under ceil(per/2)
        rz_on = ({1'b0, st_reg.ph} + 17'h00001) < (({1'b0, st_reg.per} + 17'h00001) >> 1);
    end
    // next state
    always_comb
    begin
        st_next = st_reg;
        // crystal /15 divider runs all the time
        if (xtal_tick)
        begin
            st_next.x15 = (st_reg.x15 == DPW_X15_LAST) ? 4'h0 : st_reg.x15 + 4'h1;
        end
        st_next.ext_prev = external_clock_pin;
        // prescaler
        if (src_tick)
        begin
            st_next.pre = ctick ? 6'h00 : st_reg.pre + 6'h01;
        end
        // half-clock timing for return-to-zero
        if (ctick)
        begin
            st_next.ph = DPW_ZERO16;
            st_next.per = (st_reg.ph == DPW_FULL) ? DPW_FULL : st_reg.ph + DPW_ONE16;
        end
        else if (st_reg.ph != DPW_FULL)
        begin
            st_next.ph = st_reg.ph + DPW_ONE16;
        end
        // counters and modulators advance on the counter clock
        if (ctick && (mode != DPW_M_OFF) && (mode != DPW_M_RSV))
        begin
            st_next.cnt = wrap ? DPW_ZERO16 : st_reg.cnt + DPW_ONE16;
            if (wrap)
            begin
                // new values only from the start of the next cycle
                st_next.act_a = st_reg.pend_a;
                st_next.act_b = st_reg.pend_b;
            end
            case (mode)
                DPW_M_SINGLE:
                begin
                    st_next.lvl_a = 1'b0;
                    st_next.lvl_b = st_reg.cnt < st_reg.act_a;
                end
                DPW_M_TWIN8:
                begin
                    st_next.lvl_a = st_reg.cnt[7:0] < st_reg.act_a[7:0];
                    st_next.lvl_b = (st_reg.cnt[7:0] >= st_reg.act_b[15:8]) &&
                                    (st_reg.cnt[7:0] < st_reg.act_a[15:8]);
                end
                DPW_M_TWIN16:
                begin
                    // both compare the same counter, so both rise at zero together
                    st_next.lvl_a = st_reg.cnt < st_reg.act_a;
                    st_next.lvl_b = st_reg.cnt < st_reg.act_b;
                end
                DPW_M_DUAL8:
                begin
                    st_next.cnt_b = (st_reg.cnt_b == st_reg.act_b[15:8]) ? DPW_ZERO8 : st_reg.cnt_b + 8'h01;
                    st_next.lvl_a = st_reg.cnt[7:0] < st_reg.act_a[7:0];
                    st_next.lvl_b = st_reg.cnt_b < st_reg.act_a[15:8];
                end
                default:
                begin
                    // carry out spreads the highs evenly over 65536 clocks
                    st_next.acc_a = sum_a[15:0];
                    st_next.acc_b = sum_b[15:0];
                    st_next.lvl_a = sum_a[16];
                    st_next.lvl_b = sum_b[16];
                end
            endcase
        end
        // register writes, taken at the completing edge only
        if (wr_go)
        begin
            case (paddr)
                DPW_OFF_CTL:
                begin
                    st_next.ctl = pwdata[7:0];
                    // restart: counters, prescaler, accumulators, fresh values
                    st_next.cnt = DPW_ZERO16;
                    st_next.cnt_b = DPW_ZERO8;
                    st_next.pre = 6'h00;
                    st_next.acc_a = DPW_ZERO16;
                    st_next.acc_b = DPW_ZERO16;
                    st_next.act_a = st_reg.pend_a;
                    st_next.act_b = st_reg.pend_b;
                    st_next.lvl_a = 1'b0;
                    st_next.lvl_b = 1'b0;
                end
                DPW_OFF_A_LO:
                begin
                    st_next.hold_a = pwdata[7:0];
                    // byte-wide modes take the low byte at once
                    st_next.pend_a[7:0] = dpw_wide(mode) ? st_reg.pend_a[7:0] : pwdata[7:0];
                end
                DPW_OFF_A_HI: st_next.pend_a = dpw_wide(mode) ? {pwdata[7:0], st_reg.hold_a}
                                                               : {pwdata[7:0], st_reg.pend_a[7:0]};
                DPW_OFF_B_LO:
                begin
                    st_next.hold_b = pwdata[7:0];
                    st_next.pend_b[7:0] = dpw_wide(mode) ? st_reg.pend_b[7:0] : pwdata[7:0];
                end
                DPW_OFF_B_HI: st_next.pend_b = dpw_wide(mode) ? {pwdata[7:0], st_reg.hold_b}
                                                               : {pwdata[7:0], st_reg.pend_b[7:0]};
                default: st_next.ctl = st_reg.ctl; // status is read-only
            endcase
        end
        // apb: one wait state so read data comes from a flop
        st_next.rdy = psel && penable && !st_reg.rdy;
        st_next.err = psel && penable && !st_reg.rdy && !dpw_mapped(paddr);
        if (psel && penable && !st_reg.rdy)
        begin
            case (paddr)
                DPW_OFF_CTL: st_next.rdata = {24'h000000, st_reg.ctl};
                DPW_OFF_A_LO: st_next.rdata = {24'h000000, st_reg.pend_a[7:0]};
                DPW_OFF_A_HI: st_next.rdata = {24'h000000, st_reg.pend_a[15:8]};
                DPW_OFF_B_LO: st_next.rdata = {24'h000000, st_reg.pend_b[7:0]};
                DPW_OFF_B_HI: st_next.rdata = {24'h000000, st_reg.pend_b[15:8]};
                DPW_OFF_STAT: st_next.rdata = {16'h0000, st_reg.cnt};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        // pin drivers follow the control value being written this edge
        nmode = st_next.ctl[DPW_MODE_HI:DPW_MODE_LO];
        st_next.oe_b = (nmode != DPW_M_OFF) && (nmode != DPW_M_RSV);
        st_next.oe_a = st_next.oe_b && (nmode != DPW_M_SINGLE) && !st_next.ctl[DPW_BIT_REL];
        if (mode == DPW_M_RZ)
        begin
            // high only in the first half of each counter clock
            st_next.out_a = st_next.oe_a && st_next.lvl_a && (ctick || rz_on);
            st_next.out_b = st_next.oe_b && st_next.lvl_b && (ctick || rz_on);
        end
        else
        begin
            st_next.out_a = st_next.oe_a && st_next.lvl_a;
            st_next.out_b = st_next.oe_b && st_next.lvl_b;
        end
    end
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
    // outputs straight from flops
    assign prdata = st_reg.rdata;
    assign pready = st_reg.rdy;
    assign pslverr = st_reg.err;
    assign output_a = st_reg.out_a;
    assign output_a_oe = st_reg.oe_a;
    assign output_b = st_reg.out_b;
    assign output_b_oe = st_reg.oe_b;
    // checks on the block's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_ctl_write;
        ctl_wr;
    endsequence
    sequence s_counter_zero;
        st_reg.cnt == DPW_ZERO16;
    endsequence
    a_release_a: assert property (st_reg.ctl[DPW_BIT_REL] |-> !output_a_oe)
        else $error("output a driven while released");
    a_idle_quiet: assert property ((mode == DPW_M_OFF || mode == DPW_M_RSV) |-> !output_a_oe && !output_b_oe)
        else $error("output driven in idle mode");
    a_ctl_restart: assert property (s_ctl_write |=> s_counter_zero)
        else $error("counter not restarted by control write");
    a_prescale_bound: assert property (st_reg.pre <= dpw_pre_last(st_reg.ctl[DPW_DIV_HI:DPW_DIV_LO]) ||
                                       $past(ctl_wr))
        else $error("prescaler beyond terminal count");
    a_twin16_roll: assert property (mode == DPW_M_TWIN16 && ctick && !ctl_wr && st_reg.cnt == DPW_FULL
                                    |=> s_counter_zero)
        else $error("twin 16-bit counter did not roll over");
    a_twin16_sync: assert property (mode == DPW_M_TWIN16 && ctick && !ctl_wr && st_reg.cnt == DPW_ZERO16 &&
                                    !st_reg.ctl[DPW_BIT_REL] && st_reg.act_a != DPW_ZERO16 &&
                                    st_reg.act_b != DPW_ZERO16 |=> output_a && output_b)
        else $error("outputs not high together at rollover");
    a_sd_carry: assert property (mode == DPW_M_NRZ && ctick && !ctl_wr |=> output_b == $past(sum_b[16]))
        else $error("sigma-delta output differs from carry");
    a_hold_commit: assert property (wr_go && paddr == DPW_OFF_A_HI && dpw_wide(mode)
                                    |=> st_reg.pend_a == {$past(pwdata[7:0]), $past(st_reg.hold_a)})
        else $error("high byte write did not commit held low byte");
    a_twin8_fall: assert property (mode == DPW_M_TWIN8 && ctick && !ctl_wr &&
                                   st_reg.cnt[7:0] == st_reg.act_a[7:0] |=> !output_a)
        else $error("output a not low at duty match");
    a_rz_return: assert property (mode == DPW_M_RZ && !ctick && !rz_on |=> !output_b)
        else $error("rz output high in second half");
endmodule
`default_nettype wire

// *** dpw_pkg.sv ***
// Purpose: constants and register map for the dual pwm / sigma-delta modulator
// Assumes: 32-bit apb data, one word per register
// Notes: shared by the modulator top and its bench
package dpw_pkg;
    // register byte offsets
    localparam logic [7:0] DPW_OFF_CTL = 8'h00;
    localparam logic [7:0] DPW_OFF_A_LO = 8'h04;
    localparam logic [7:0] DPW_OFF_A_HI = 8'h08;
    localparam logic [7:0] DPW_OFF_B_LO = 8'h0C;
    localparam logic [7:0] DPW_OFF_B_HI = 8'h10;
    localparam logic [7:0] DPW_OFF_STAT = 8'h14;
    // control field positions
    localparam int DPW_BIT_REL = 7;
    localparam int DPW_MODE_HI = 6;
    localparam int DPW_MODE_LO = 4;
    localparam int DPW_DIV_HI = 3;
    localparam int DPW_DIV_LO = 2;
    localparam int DPW_SRC_HI = 1;
    localparam int DPW_SRC_LO = 0;
    localparam logic [7:0] DPW_CTL_RST = 8'h00;
    // mode codes
    localparam logic [2:0] DPW_M_OFF = 3'h0;
    localparam logic [2:0] DPW_M_SINGLE = 3'h1;
    localparam logic [2:0] DPW_M_TWIN8 = 3'h2;
    localparam logic [2:0] DPW_M_TWIN16 = 3'h3;
    localparam logic [2:0] DPW_M_NRZ = 3'h4;
    localparam logic [2:0] DPW_M_DUAL8 = 3'h5;
    localparam logic [2:0] DPW_M_RZ = 3'h6;
    localparam logic [2:0] DPW_M_RSV = 3'h7;
    // clock source codes
    localparam logic [1:0] DPW_SRC_X15 = 2'h0;
    localparam logic [1:0] DPW_SRC_XTAL = 2'h1;
    localparam logic [1:0] DPW_SRC_EXT = 2'h2;
    localparam logic [1:0] DPW_SRC_VCO = 2'h3;
    // crystal divide-by-15 terminal count
    localparam logic [3:0] DPW_X15_LAST = 4'hE;
    // prescaler terminal counts for /1 /4 /16 /64
    localparam logic [5:0] DPW_PRE_L1 = 6'h00;
    localparam logic [5:0] DPW_PRE_L4 = 6'h03;
    localparam logic [5:0] DPW_PRE_L16 = 6'h0F;
    localparam logic [5:0] DPW_PRE_L64 = 6'h3F;
    localparam logic [15:0] DPW_FULL = 16'hFFFF;
    localparam logic [15:0] DPW_ZERO16 = 16'h0000;
    localparam logic [15:0] DPW_ONE16 = 16'h0001;
    localparam logic [7:0] DPW_ZERO8 = 8'h00;
endpackage

// *** dpw_load.sv ***
// Purpose: load model on the two modulator pins, counting highs and rising edges
// Assumes: both pins carry a pull-down, so a released pin reads low
// Notes: counts restart on the first cycle of every measurement window
`timescale 1ns/1ps
`default_nettype none
module dpw_load (
    // clock
    input wire logic pclk,
    // pins from the block
    input wire logic output_a,
    input wire logic output_a_oe,
    input wire logic output_b,
    input wire logic output_b_oe,
    // measurement window, high while counting
    input wire logic en,
    // results of the last window
    output logic [31:0] hi_a,
    output logic [31:0] hi_b,
    output logic [31:0] rise_a,
    output logic [31:0] rise_b
);
    logic pin_a; // level seen on pin a
    logic pin_b; // level seen on pin b
    logic pa_q; // pin a one cycle back
    logic pb_q; // pin b one cycle back
    logic en_q; // window flag one cycle back
    // released pin falls to the pull-down, it never keeps the last driven level
    assign pin_a = output_a_oe & output_a;
    assign pin_b = output_b_oe & output_b;
    // counters; a window whose length is a whole number of periods gives exact counts
    always_ff @(posedge pclk)
    begin
        pa_q <= pin_a;
        pb_q <= pin_b;
        en_q <= en;
        if (en && !en_q)
        begin
            // first sample of a window starts the counts afresh
            hi_a <= {31'h0, pin_a};
            hi_b <= {31'h0, pin_b};
            rise_a <= {31'h0, pin_a & ~pa_q};
            rise_b <= {31'h0, pin_b & ~pb_q};
        end
        else if (en)
        begin
            hi_a <= hi_a + {31'h0, pin_a};
            hi_b <= hi_b + {31'h0, pin_b};
            rise_a <= rise_a + {31'h0, pin_a & ~pa_q};
            rise_b <= rise_b + {31'h0, pin_b & ~pb_q};
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the dual pwm / sigma-delta modulator
// Assumes: apb master on pclk, crystal tick every pclk, pull-down load on pins
// Notes: duty is judged by counting pin highs over whole periods
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import dpw_pkg::*;
    // apb
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // clock sources
    logic xtal_tick = 1'b1; // crystal at pclk rate
    logic vco_tick = 1'b0; // pulse every second pclk
    logic ext_man = 1'b0; // hand-driven pin level
    logic ext_free = 1'b0; // pin runs free when set
    logic [1:0] ext_cnt = 2'h0;
    logic ext_pin;
    // pins and load results
    logic output_a;
    logic output_a_oe;
    logic output_b;
    logic output_b_oe;
    logic en = 1'b0;
    logic [31:0] hi_a;
    logic [31:0] hi_b;
    logic [31:0] rise_a;
    logic [31:0] rise_b;
    int bad_count = 0;
    int n_checks = 0;
    // 50 MHz
    always #10 pclk = ~pclk;
    // free-running sources; pin period of four pclks
    always @(posedge pclk)
    begin
        vco_tick <= ~vco_tick;
        ext_cnt <= ext_cnt + 2'h1;
    end
    assign ext_pin = ext_free ? ext_cnt[1] : ext_man;
    dpw_modulator i_dpw_modulator (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xtal_tick(xtal_tick), .vco_tick(vco_tick), .external_clock_pin(ext_pin),
        .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b), .output_b_oe(output_b_oe));
    dpw_load i_dpw_load (.pclk(pclk), .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b),
        .output_b_oe(output_b_oe), .en(en), .hi_a(hi_a), .hi_b(hi_b), .rise_a(rise_a), .rise_b(rise_b));
    // verdict and end of run
    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask
    // mode first, then data, then control again so the new values load at once
    task automatic cfg(input logic [7:0] c, input logic [7:0] al, input logic [7:0] ah, input logic [7:0] bl,
        input logic [7:0] bh);
        wr(DPW_OFF_CTL, c);
        wr(DPW_OFF_A_LO, al);
        wr(DPW_OFF_A_HI, ah);
        wr(DPW_OFF_B_LO, bl);
        wr(DPW_OFF_B_HI, bh);
        wr(DPW_OFF_CTL, c);
    endtask
    // let the waveform settle, then count over n pclks
    task automatic meas(input int settle, input int n);
        repeat (settle) @(posedge pclk);
        en <= 1'b1;
        repeat (n) @(posedge pclk);
        en <= 1'b0;
        @(posedge pclk);
    endtask
    // reset values, readback and bus refusal
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, DPW_OFF_CTL, 32'h0, r, e);
        `CHK("ctl reset", 32'h0, r)
        `CHK("a oe idle", 1'b0, output_a_oe)
        `CHK("b oe idle", 1'b0, output_b_oe)
        wr(DPW_OFF_CTL, 8'h35);
        apb(1'b0, DPW_OFF_CTL, 32'h0, r, e);
        `CHK("ctl readback", 32'h35, r)
        apb(1'b0, 8'h18, 32'h0, r, e);
        `CHK("unmapped err", 1'b1, e)
    endtask
    // pin edges advance the counter, a control write clears it
    task automatic t_restart();
        logic [31:0] r;
        logic e;
        cfg(8'h22, 8'h04, 8'h07, 8'h09, 8'h02);
        repeat (3)
        begin
            @(posedge pclk);
            ext_man <= 1'b1;
            repeat (3) @(posedge pclk);
            ext_man <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        apb(1'b0, DPW_OFF_STAT, 32'h0, r, e);
        `CHK("count after pin", 32'h3, r)
        wr(DPW_OFF_CTL, 8'h22);
        apb(1'b0, DPW_OFF_STAT, 32'h0, r, e);
        `CHK("count cleared", 32'h0, r)
    endtask
    // twin 8-bit with period 10, then with output a released
    task automatic t_twin8();
        cfg(8'h21, 8'h04, 8'h07, 8'h09, 8'h02);
        meas(24, 40);
        `CHK("twin8 a highs", 32'h10, hi_a)
        `CHK("twin8 b highs", 32'h14, hi_b)
        `CHK("twin8 a periods", 32'h4, rise_a)
        wr(DPW_OFF_CTL, 8'hA1);
        meas(24, 40);
        `CHK("released a oe", 1'b0, output_a_oe)
        `CHK("released a highs", 32'h0, hi_a)
        `CHK("kept b highs", 32'h14, hi_b)
    endtask
    // dual 8-bit, periods 8 and 5, both under one /4 prescale
    task automatic t_dual8();
        cfg(8'h55, 8'h03, 8'h02, 8'h07, 8'h04);
        meas(64, 160);
        `CHK("dual8 a highs", 32'h3C, hi_a)
        `CHK("dual8 b highs", 32'h40, hi_b)
    endtask
    // single mode, period 16 duty 5, only b driven
    task automatic t_single();
        cfg(8'h11, 8'h05, 8'h00, 8'h10, 8'h00);
        meas(40, 64);
        `CHK("single b highs", 32'h14, hi_b)
        `CHK("single a oe", 1'b0, output_a_oe)
    endtask
    // nrz density: quarter and three quarters
    task automatic t_nrz();
        cfg(8'h41, 8'h00, 8'h40, 8'h00, 8'hC0);
        meas(16, 64);
        `CHK("nrz a highs", 32'h10, hi_a)
        `CHK("nrz b highs", 32'h30, hi_b)
    endtask
    // half scale toggles every tick, so rises count half the ticks of each divide
    task automatic t_prescale();
        for (int i = 0; i < 4; i++)
        begin
            cfg({4'h4, i[1:0], 2'h1}, 8'h00, 8'h80, 8'h00, 8'h80);
            meas(300, 256);
            `CHK("prescale rises", 32'h80 >> (2 * i), rise_a)
        end
    endtask
    // each clock source at half scale
    task automatic t_source();
        logic [31:0] exp_r [4];
        exp_r = '{32'h08, 32'h78, 32'h1E, 32'h3C};
        ext_free <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            cfg({6'h10, s[1:0]}, 8'h00, 8'h80, 8'h00, 8'h80);
            meas(60, 240);
            `CHK("source rises", exp_r[s], rise_a)
        end
        ext_free <= 1'b0;
    endtask
    // rz with /4: each high tick shows two pclks high
    task automatic t_rz();
        cfg(8'h65, 8'h00, 8'h80, 8'h00, 8'h40);
        meas(64, 128);
        `CHK("rz a highs", 32'h20, hi_a)
        `CHK("rz b highs", 32'h10, hi_b)
        `CHK("rz a pulses", 32'h10, rise_a)
    endtask
    // low byte waits hidden until the high byte commits it
    task automatic t_hold();
        logic [31:0] r;
        logic e;
        wr(DPW_OFF_B_LO, 8'hFF);
        apb(1'b0, DPW_OFF_B_LO, 32'h0, r, e);
        `CHK("held low hidden", 32'h0, r)
        wr(DPW_OFF_B_HI, 8'h40);
        apb(1'b0, DPW_OFF_B_LO, 32'h0, r, e);
        `CHK("low committed", 32'hFF, r)
    endtask
    // reserved code drives nothing
    task automatic t_rsv();
        wr(DPW_OFF_CTL, 8'h71);
        meas(8, 32);
        `CHK("rsv a oe", 1'b0, output_a_oe)
        `CHK("rsv b oe", 1'b0, output_b_oe)
        `CHK("rsv b highs", 32'h0, hi_b)
    endtask
    // twin 16-bit over one full 65536 period
    task automatic t_twin16();
        cfg(8'h31, 8'h00, 8'h01, 8'h00, 8'h03);
        meas(4, 65536);
        `CHK("twin16 a highs", 32'h100, hi_a)
        `CHK("twin16 b highs", 32'h300, hi_b)
        `CHK("twin16 a rises", 32'h1, rise_a)
        `CHK("twin16 b rises", 32'h1, rise_b)
    endtask
    // main sequence
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_restart();
        t_twin8();
        t_dual8();
        t_single();
        t_nrz();
        t_prescale();
        t_source();
        t_rz();
        t_hold();
        t_rsv();
        t_twin16();
        end_sim();
    end
    // watchdog, well past the expected run of about 70000 cycles
    initial
    begin
        repeat (90000) @(posedge pclk);
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
